//--- rtl/pvmrf_top.sv
// per-processor base, buffer address and buffer data register files
//
// Function
// - eight 24-bit base registers, one each
// - base write needs card, word select, nibbles
// - bit-op writes only mask-one bits of each enabled nibble
// - load base writes all three bytes
// - wide writes combine nibble enables
// - base read per byte to the main bus, as whole 24 bits to the indexer
// - active base continuously presented to indexer
// - per-byte enables gate base read selects
// - address load writes active buffer address
// - selected buffer address driven to memory
// - memory word captured into selected buffer
// - buffer data halves loaded from bus two
// - active buffer data continuously to indexer
// - main bus enable drives active buffer data
// - next instruction enable drives active buffer
// - write selector drives buffer onto write bus
// - three-bit active processor code
`timescale 1ns/100ps
module pvmrf_top
   import pvmrf_pkg::*;
(
   // clock, reset, enable
   input  wire logic                      mclk_i,
   input  wire logic                      nrst_i,
   input  wire logic                      clk_en_i,
   // active processor
   input  wire pvmrf_pkg::pvmrf_vp_t      active_vp_i,
   // arithmetic transfer bus two
   input  wire logic [pvmrf_pkg::WORD_W-1:0] arith_transfer_bus_two_i,
   // base register writes
   input  wire logic                      base_file_card_select_i,
   input  wire pvmrf_pkg::pvmrf_vp_t      base_word_select_i,
   input  wire logic [pvmrf_pkg::BASE_BYTES-1:0] right_nibble_wr_en_i,
   input  wire logic [pvmrf_pkg::BASE_BYTES-1:0] left_nibble_wr_en_i,
   input  wire logic [pvmrf_pkg::NIB_W-1:0] field_bit_mask_i,
   input  wire logic                      bit_op_instr_i,
   input  wire logic                      load_base_instr_i,
   // base register reads to the main data bus
   input  wire logic [pvmrf_pkg::BASE_BYTES-1:0] base_read_byte_en_i,
   input  wire pvmrf_pkg::pvmrf_vp_t      base_read_select1_i,
   input  wire pvmrf_pkg::pvmrf_vp_t      base_read_select2_i,
   input  wire pvmrf_pkg::pvmrf_vp_t      base_read_select3_i,
   // buffer address control
   input  wire logic                      addr_load_en_i,
   input  wire logic [pvmrf_pkg::WORD_W-1:0] addr_source_i,
   input  wire pvmrf_pkg::pvmrf_vp_t      addr_out_select_i,
   // buffer data control
   input  wire logic                      mem_data_load_en_i,
   input  wire pvmrf_pkg::pvmrf_vp_t      mem_data_load_select_i,
   input  wire logic [pvmrf_pkg::WORD_W-1:0] mem_read_data_i,
   input  wire logic                      data_left_half_en_i,
   input  wire logic                      data_right_half_en_i,
   input  wire pvmrf_pkg::pvmrf_vp_t      data_write_select_i,
   input  wire logic                      data_to_main_bus_en_i,
   input  wire logic                      data_to_next_instr_en_i,
   input  wire pvmrf_pkg::pvmrf_vp_t      mem_write_selector_i,
   // indexer outputs
   output logic [pvmrf_pkg::BASE_W-1:0]   idx_base_o,
   output logic [pvmrf_pkg::WORD_W-1:0]   idx_data_o,
   // main data bus
   output logic [pvmrf_pkg::WORD_W-1:0]   main_data_bus_o,
   output logic                           main_bus_valid_o,
   // next instruction register feed
   output logic [pvmrf_pkg::WORD_W-1:0]   next_instr_data_o,
   output logic                           next_instr_load_o,
   // central memory
   output logic [pvmrf_pkg::WORD_W-1:0]   mem_addr_o,
   output logic [pvmrf_pkg::WORD_W-1:0]   memory_write_bus_o
);
   import pvmrf_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // storage
   ////////////////////////////////////////////////////////////////////////

   // base registers, byte one in the top bits
   logic [BASE_W-1:0] base_file   [VP_CNT];
   // buffer address registers
   logic [WORD_W-1:0] buf_addr    [VP_CNT];
   // buffer data registers
   logic [WORD_W-1:0] buffer_data_reg [VP_CNT];

   // base write decode
   logic [BASE_W-1:0] base_wmask;     // bits that this write touches
   logic [BASE_W-1:0] base_wdata;     // bus slice that feeds the base
   pvmrf_vp_t         base_wsel;      // target base register
   logic              base_we;        // any base write this cycle
   logic [NIB_W-1:0]  eff_mask;       // field mask after load forcing
   logic [BASE_BYTES-1:0] eff_right;  // right nibble enables after forcing
   logic [BASE_BYTES-1:0] eff_left;   // left nibble enables after forcing
   // base read assembly for the main data bus
   logic [BASE_W-1:0] base_rd;        // assembled base bytes
   logic              base_rd_any;    // any byte enable active

   ////////////////////////////////////////////////////////////////////////
   // base register writes
   ////////////////////////////////////////////////////////////////////////

   // load forces enables
   // a base load overrides the card enables so all three bytes land
   always_comb begin
      if (load_base_instr_i) begin
         eff_right = '1;
         eff_left  = '1;
         eff_mask  = MASK_ALL;
      end else begin
         eff_right = right_nibble_wr_en_i;
         eff_left  = left_nibble_wr_en_i;
         // mask bit ops
         // outside bit ops every bit of an enabled nibble is written
         eff_mask  = bit_op_instr_i ? field_bit_mask_i : MASK_ALL;
      end
   end

   // nibble enables combine
   // each enabled nibble opens its four bits through the field mask
   always_comb begin
      base_wmask = '0;
      for (int b = 0; b < BASE_BYTES; b++) begin
         if (eff_right[b]) begin
            base_wmask[BASE_BYTE1_LSB - b*BYTE_W + RIGHT_NIB_OFS +: NIB_W]
               = eff_mask;
         end
         if (eff_left[b]) begin
            base_wmask[BASE_BYTE1_LSB - b*BYTE_W + LEFT_NIB_OFS +: NIB_W]
               = eff_mask;
         end
      end
   end

   // bus bit placement
   // bus bits 12-15 land in the right nibble of byte one
   assign base_wdata = arith_transfer_bus_two_i[BASE_W-1:0];

   // card and word select
   // a load targets the active processor; otherwise the word select
   assign base_wsel = load_base_instr_i ? active_vp_i : base_word_select_i;
   assign base_we   = load_base_instr_i ||
                      (base_file_card_select_i && (|base_wmask));

   // unselected bases hold
   // no reset: contents are undefined until software loads them
   always_ff @(posedge mclk_i) begin
      if (clk_en_i && base_we) begin
         base_file[base_wsel] <= (base_file[base_wsel] & ~base_wmask) |
                                 (base_wdata & base_wmask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // buffer address registers
   ////////////////////////////////////////////////////////////////////////

   always_ff @(posedge mclk_i) begin
      if (clk_en_i && addr_load_en_i) begin
         buf_addr[active_vp_i] <= addr_source_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // buffer data registers
   ////////////////////////////////////////////////////////////////////////

   // halfword loads
   // a bus-two half write in the same cycle overrides the memory word
   // for that half, since it is the later request of the processor
   always_ff @(posedge mclk_i) begin
      if (clk_en_i) begin
         for (int v = 0; v < VP_CNT; v++) begin
            if (mem_data_load_en_i && (mem_data_load_select_i == v[VP_W-1:0]))
            begin
               buffer_data_reg[v] <= mem_read_data_i;
            end
            if (data_left_half_en_i && (data_write_select_i == v[VP_W-1:0]))
            begin
               buffer_data_reg[v][LEFT_HALF_LSB +: HALF_W] <=
                  arith_transfer_bus_two_i[LEFT_HALF_LSB +: HALF_W];
            end
            if (data_right_half_en_i && (data_write_select_i == v[VP_W-1:0]))
            begin
               buffer_data_reg[v][RIGHT_HALF_LSB +: HALF_W] <=
                  arith_transfer_bus_two_i[RIGHT_HALF_LSB +: HALF_W];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // indexer feeds
   ////////////////////////////////////////////////////////////////////////

   // active code decode
   // registered, so the indexer sees the value one clock later
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         idx_base_o <= BASE_RST;
         idx_data_o <= WORD_RST;
      end else if (clk_en_i) begin
         idx_base_o <= base_file[active_vp_i];
         idx_data_o <= buffer_data_reg[active_vp_i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main data bus
   ////////////////////////////////////////////////////////////////////////

   // per-byte read decode
   // each byte enable gates only its own select decode
   always_comb begin
      base_rd = '0;
      if (base_read_byte_en_i[0]) begin
         base_rd[BASE_BYTE1_LSB +: BYTE_W] =
            base_file[base_read_select1_i][BASE_BYTE1_LSB +: BYTE_W];
      end
      if (base_read_byte_en_i[1]) begin
         base_rd[BASE_BYTE1_LSB - BYTE_W +: BYTE_W] =
            base_file[base_read_select2_i][BASE_BYTE1_LSB - BYTE_W +: BYTE_W];
      end
      if (base_read_byte_en_i[2]) begin
         base_rd[BASE_BYTE1_LSB - 2*BYTE_W +: BYTE_W] =
            base_file[base_read_select3_i][BASE_BYTE1_LSB - 2*BYTE_W +: BYTE_W];
      end
   end
   assign base_rd_any = |base_read_byte_en_i;

   // whole base word
   // buffer data wins if both sources are enabled; upper byte reads zero
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         main_data_bus_o  <= WORD_RST;
         main_bus_valid_o <= 1'b0;
      end else if (clk_en_i) begin
         main_bus_valid_o <= data_to_main_bus_en_i || base_rd_any;
         if (data_to_main_bus_en_i) begin
            main_data_bus_o <= buffer_data_reg[active_vp_i];
         end else if (base_rd_any) begin
            main_data_bus_o <= {{(WORD_W-BASE_W){1'b0}}, base_rd};
         end else begin
            main_data_bus_o <= WORD_RST;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next instruction feed
   ////////////////////////////////////////////////////////////////////////

   // data to next instruction
   // data holds after the strobe so the register can latch late
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         next_instr_data_o <= WORD_RST;
         next_instr_load_o <= 1'b0;
      end else if (clk_en_i) begin
         next_instr_load_o <= data_to_next_instr_en_i;
         if (data_to_next_instr_en_i) begin
            next_instr_data_o <= buffer_data_reg[active_vp_i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // central memory outputs
   ////////////////////////////////////////////////////////////////////////

   // data to write bus
   // the controller owns the selects; both paths follow them every cycle
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         mem_addr_o         <= WORD_RST;
         memory_write_bus_o <= WORD_RST;
      end else if (clk_en_i) begin
         mem_addr_o         <= buf_addr[addr_out_select_i];
         memory_write_bus_o <= buffer_data_reg[mem_write_selector_i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   ////////////////////////////////////////////////////////////////////////

   // helper views and captured selects, read only by the checks
   logic [BASE_W-1:0] cur_base;       // active base before the edge
   logic [BASE_W-1:0] cur_wbase;      // write target before the edge
   logic [WORD_W-1:0] cur_data;       // active buffer data before the edge
   pvmrf_vp_t         hlp_vp;         // active code at the last edge
   pvmrf_vp_t         hlp_wsel;       // base target at the last edge
   pvmrf_vp_t         hlp_dsel;       // memory load select, last edge
   assign cur_base  = base_file[active_vp_i];
   assign cur_wbase = base_file[base_wsel];
   assign cur_data  = buffer_data_reg[active_vp_i];
   always_ff @(posedge mclk_i) begin
      if (clk_en_i) begin
         hlp_vp   <= active_vp_i;
         hlp_wsel <= base_wsel;
         hlp_dsel <= mem_data_load_select_i;
      end
   end

   // every check shares the one clock and is off while reset is low
   default clocking cb_chk @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   // next instruction request and its answer
   sequence seq_ni_req;
      clk_en_i && data_to_next_instr_en_i;
   endsequence
   sequence seq_ni_ans;
      next_instr_load_o && next_instr_data_o == $past(cur_data);
   endsequence

   AST_BASE_IDX: assert property (
      clk_en_i |=> idx_base_o == $past(cur_base))
      else $error("indexer base not the active base");
   AST_BASE_LOAD: assert property (
      clk_en_i && load_base_instr_i |=>
         base_file[hlp_vp] == $past(base_wdata))
      else $error("base load did not write all three bytes");
   AST_MASK_KEEP: assert property (
      clk_en_i && base_we |=>
         (base_file[hlp_wsel] & ~$past(base_wmask)) ==
         ($past(cur_wbase) & ~$past(base_wmask)))
      else $error("base bits outside mask changed");
   AST_ADDR_LOAD: assert property (
      clk_en_i && addr_load_en_i |=>
         buf_addr[hlp_vp] == $past(addr_source_i))
      else $error("buffer address not loaded");
   AST_ADDR_OUT: assert property (
      clk_en_i && addr_load_en_i && (addr_out_select_i == active_vp_i)
      ##1 clk_en_i && $stable(addr_out_select_i) && !addr_load_en_i
      |=> mem_addr_o == $past(addr_source_i, 2))
      else $error("memory address not the loaded buffer address");
   AST_MEM_LOAD: assert property (
      clk_en_i && mem_data_load_en_i && !data_left_half_en_i &&
      !data_right_half_en_i |=>
         buffer_data_reg[hlp_dsel] == $past(mem_read_data_i))
      else $error("memory word not captured");
   AST_MAIN_BUS: assert property (
      clk_en_i && data_to_main_bus_en_i |=>
         main_bus_valid_o && main_data_bus_o == $past(cur_data))
      else $error("main bus not driven from buffer data");
   AST_NEXT_INSTR: assert property (
      seq_ni_req |=> seq_ni_ans)
      else $error("next instruction data not the active buffer");
   AST_WRITE_BUS: assert property (
      clk_en_i && !mem_data_load_en_i && !data_left_half_en_i &&
      !data_right_half_en_i ##1 clk_en_i && $stable(mem_write_selector_i)
      |=> memory_write_bus_o == $past(memory_write_bus_o))
      else $error("write bus not steady for a steady selector");
   AST_BASE_READ: assert property (
      clk_en_i && !data_to_main_bus_en_i && !base_read_byte_en_i[0] |=>
         main_data_bus_o[BASE_BYTE1_LSB +: BYTE_W] == '0)
      else $error("unenabled base byte reached the main bus");

endmodule : pvmrf_top

//--- rtl/pvmrf_pkg.sv
// constants shared by the per-processor memory register files
package pvmrf_pkg;
   // processor count and code width
   localparam int VP_CNT     = 8;
   localparam int VP_W       = 3;
   // datapath widths
   localparam int WORD_W     = 32;
   localparam int HALF_W     = 16;
   localparam int BYTE_W     = 8;
   localparam int NIB_W      = 4;
   localparam int BASE_W     = 24;
   localparam int BASE_BYTES = 3;
   // base byte one occupies transfer bus bits 8-15 (msb first numbering)
   localparam int BASE_BYTE1_LSB = 16;
   // right nibble of byte one is bus bits 12-15
   localparam int RIGHT_NIB_OFS  = 0;
   localparam int LEFT_NIB_OFS   = 4;
   // halfword positions in a word
   localparam int LEFT_HALF_LSB  = 16;
   localparam int RIGHT_HALF_LSB = 0;
   // full field mask forced on a base load
   localparam logic [NIB_W-1:0] MASK_ALL = 4'hF;
   // reset value of every output flip-flop
   localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
   localparam logic [BASE_W-1:0] BASE_RST = 24'h00_0000;
   // processor code type
   typedef logic [VP_W-1:0] pvmrf_vp_t;
endpackage : pvmrf_pkg

//--- bench/pvmrf_mem_model.sv
// memory controller and central memory facing the register files
`timescale 1ns/100ps
module pvmrf_mem_model
   import pvmrf_pkg::*;
(
   // clock
   input  wire logic                         mclk_i,
   // from the register files
   input  wire logic [pvmrf_pkg::WORD_W-1:0] mem_addr_i,
   input  wire logic [pvmrf_pkg::WORD_W-1:0] write_bus_i,
   // controller selects and read data
   output pvmrf_pkg::pvmrf_vp_t              addr_select_o,
   output logic                              load_en_o,
   output pvmrf_pkg::pvmrf_vp_t              load_select_o,
   output logic [pvmrf_pkg::WORD_W-1:0]      read_data_o,
   output pvmrf_pkg::pvmrf_vp_t              write_select_o
);
   // sixteen words are enough; the low address nibble picks one
   logic [WORD_W-1:0] mem [16];
   ////////////////////////////////////////////////////////////////////
   // idle state with a known fill pattern
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 32'hC0DE_0000 + i;
      end
      addr_select_o  = 3'h0;
      load_en_o      = 1'b0;
      load_select_o  = 3'h0;
      read_data_o    = 32'h5A5A_5A5A;
      write_select_o = 3'h0;
   end
   ////////////////////////////////////////////////////////////////////
   // accepted read: name the requester, answer lat cycles after the address edge
   task automatic read_word(input pvmrf_vp_t vp, input int lat);
      addr_select_o = vp;
      @(posedge mclk_i);
      #1;
      repeat (lat) begin
         @(posedge mclk_i);
         #1;
      end
      load_en_o     = 1'b1;
      load_select_o = vp;
      read_data_o   = mem[mem_addr_i[3:0]];
      @(posedge mclk_i);
      #1;
      load_en_o   = 1'b0;
      // released data is not held: the simulator must not see old value
      read_data_o = ~read_data_o;
   endtask : read_word
   ////////////////////////////////////////////////////////////////////
   // accepted write: store what the write bus carries
   task automatic write_word(input pvmrf_vp_t vp);
      write_select_o = vp;
      addr_select_o  = vp;
      @(posedge mclk_i);
      #1;
      mem[mem_addr_i[3:0]] = write_bus_i;
   endtask : write_word
endmodule : pvmrf_mem_model

//--- bench/testbench.sv
// self-checking bench for the per-processor register files
`timescale 1ns/100ps
module testbench;
   import pvmrf_pkg::*;
   // bench-driven inputs
   logic              mclk_i, nrst_i, clk_en_i, card, bitop, ldb;
   logic              aload, lh, rh, to_mb, to_ni;
   pvmrf_vp_t         act, wsel, rs1, rs2, rs3, dsel;
   logic [WORD_W-1:0] bus2, asrc;
   logic [2:0]        rn, ln, rden;
   logic [NIB_W-1:0]  mask;
   // partner-driven inputs
   pvmrf_vp_t         a_sel, l_sel, w_sel;
   logic              l_en;
   logic [WORD_W-1:0] rdata;
   // design outputs
   logic [BASE_W-1:0] idx_base;
   logic [WORD_W-1:0] idx_data, main_data_bus, ni_data, maddr, wbus, exp_d;
   logic              mb_v, ni_ld;
   logic [BASE_W-1:0] r2, r3;
   int                bad_count, n_tests, cyc, v;
   ////////////////////////////////////////////////////////////////////
   pvmrf_top pvmrf_top_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .clk_en_i(clk_en_i), .active_vp_i(act),
      .arith_transfer_bus_two_i(bus2), .base_file_card_select_i(card),
      .base_word_select_i(wsel), .right_nibble_wr_en_i(rn),
      .left_nibble_wr_en_i(ln), .field_bit_mask_i(mask),
      .bit_op_instr_i(bitop), .load_base_instr_i(ldb),
      .base_read_byte_en_i(rden), .base_read_select1_i(rs1),
      .base_read_select2_i(rs2), .base_read_select3_i(rs3),
      .addr_load_en_i(aload), .addr_source_i(asrc),
      .addr_out_select_i(a_sel), .mem_data_load_en_i(l_en),
      .mem_data_load_select_i(l_sel), .mem_read_data_i(rdata),
      .data_left_half_en_i(lh), .data_right_half_en_i(rh),
      .data_write_select_i(dsel), .data_to_main_bus_en_i(to_mb),
      .data_to_next_instr_en_i(to_ni), .mem_write_selector_i(w_sel),
      .idx_base_o(idx_base), .idx_data_o(idx_data),
      .main_data_bus_o(main_data_bus), .main_bus_valid_o(mb_v),
      .next_instr_data_o(ni_data), .next_instr_load_o(ni_ld),
      .mem_addr_o(maddr), .memory_write_bus_o(wbus));
   pvmrf_mem_model pvmrf_mem_model_inst (.mclk_i(mclk_i),
      .mem_addr_i(maddr), .write_bus_i(wbus), .addr_select_o(a_sel),
      .load_en_o(l_en), .load_select_o(l_sel), .read_data_o(rdata),
      .write_select_o(w_sel));
   ////////////////////////////////////////////////////////////////////
   // 50 MHz clock and a cycle ceiling against hangs
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         $display("CHECK FAILED at %0t: timeout", $time);
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////
   // distinct base pattern per processor
   function automatic logic [BASE_W-1:0] bp(input int k);
      return {4'hB, k[3:0], 16'h5AC3};
   endfunction : bp
   task automatic tick();
      @(posedge mclk_i);
      #1;
   endtask : tick
   task automatic chk(input logic [WORD_W-1:0] got,
                      input logic [WORD_W-1:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask : chk
   task automatic ldbase(input int k, input logic [BASE_W-1:0] d);
      act  = k[2:0];
      bus2 = {8'h00, d};
      // strobe stays up between calls; the caller drops it at the end
      ldb  = 1'b1;
      tick();
   endtask : ldbase
   task automatic base_wr(input logic c, input int s, input logic [2:0] r,
      input logic [2:0] l, input logic b, input logic [3:0] m,
      input logic [BASE_W-1:0] d);
      card  = c;
      wsel  = s[2:0];
      rn    = r;
      ln    = l;
      bitop = b;
      mask  = m;
      bus2  = {8'h00, d};
      tick();
   endtask : base_wr
   // select a processor and let the registered outputs follow
   task automatic see(input int k);
      act = k[2:0];
      tick();
   endtask : see
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {card, bitop, ldb, aload, lh, rh, to_mb, to_ni} = '0;
      {act, wsel, rs1, rs2, rs3, dsel, rn, ln, rden, mask} = '0;
      {bus2, asrc, bad_count, n_tests, cyc} = '0;
      nrst_i   = 1'b0;
      clk_en_i = 1'b1;
      // storage has no reset: give bases 0-3 and buffer 0 known contents
      // while reset is low, so the checks never meet unknown values
      {lh, rh} = 2'b11;
      for (int k = 0; k < 4; k++) begin
         base_wr(1'b1, k, 3'b111, 3'b111, 1'b0, 4'hF, 24'h0);
      end
      chk(main_data_bus, 32'h0, "reset bus");
      chk({31'h0, ni_ld}, 32'h0, "reset strobe");
      {lh, rh} = 2'b00;
      nrst_i   = 1'b1;
      // the other bases while processor 0 stays active
      for (int k = 4; k < VP_CNT; k++) begin
         base_wr(1'b1, k, 3'b111, 3'b111, 1'b0, 4'hF, 24'h0);
      end
      {card, rn, ln} = '0;
      // load-base to every processor, then one frozen attempt
      for (int k = 0; k < VP_CNT; k++) begin
         ldbase(k, bp(k));
      end
      clk_en_i = 1'b0;
      ldbase(0, 24'hFFFFFF);
      ldb      = 1'b0;
      clk_en_i = 1'b1;
      for (int k = 0; k < VP_CNT; k++) begin
         see(k);
         chk({8'h00, idx_base}, {8'h00, bp(k)}, "base");
      end
      // writes without card select are ignored, byte two then bit op
      base_wr(1'b0, 2, 3'b111, 3'b111, 1'b0, 4'h0, 24'hFFFFFF);
      base_wr(1'b1, 2, 3'b010, 3'b010, 1'b0, 4'h0, 24'h123456);
      base_wr(1'b1, 3, 3'b001, 3'b000, 1'b1, 4'hA, 24'h0C0000);
      {card, rn, ln, bitop} = '0;
      r2 = (bp(2) & 24'hFF00FF) | 24'h003400;
      r3 = (bp(3) & ~24'h0A0000) | 24'h080000;
      see(2);
      chk({8'h00, idx_base}, {8'h00, r2}, "byte write");
      see(3);
      chk({8'h00, idx_base}, {8'h00, r3}, "masked write");
      see(4);
      chk({8'h00, idx_base}, {8'h00, bp(4)}, "untouched");
      // per-byte base reads to the main bus
      {rden, rs1, rs2, rs3} = {3'b111, 3'd1, 3'd2, 3'd3};
      tick();
      exp_d = {8'h00, (bp(1) & 24'hFF0000) | (r2 & 24'h00FF00)
               | (r3 & 24'h0000FF)};
      chk(main_data_bus, exp_d, "base read");
      chk({31'h0, mb_v}, 32'h1, "bus valid");
      rden = 3'b000;
      tick();
      chk(main_data_bus, 32'h0, "bus idle");
      // buffer address, memory read, outputs, half load, memory write
      for (int k = 0; k < 2; k++) begin
         // processor 0 first: the controller idles on select 0, so the
         // address load and the memory address select line up
         v     = k * 6;
         act   = v[2:0];
         asrc  = 32'h0000_4000 + v + 2;
         aload = 1'b1;
         tick();
         aload = 1'b0;
         pvmrf_mem_model_inst.read_word(v[2:0], k * 3);
         chk(maddr, 32'h0000_4000 + v + 2, "address");
         exp_d = 32'hC0DE_0000 + v + 2;
         tick();
         chk(idx_data, exp_d, "indexer data");
         to_mb = 1'b1;
         tick();
         to_mb = 1'b0;
         chk(main_data_bus, exp_d, "main bus data");
         to_ni = 1'b1;
         tick();
         to_ni = 1'b0;
         chk(ni_data, exp_d, "next instr");
         chk({31'h0, ni_ld}, 32'h1, "next strobe");
         tick();
         chk({31'h0, ni_ld}, 32'h0, "strobe ends");
         {lh, rh, dsel, bus2} = {k == 0, k == 1, v[2:0], 32'h9ABC_5678};
         tick();
         {lh, rh} = 2'b00;
         exp_d = (k == 0) ? {16'h9ABC, exp_d[15:0]}
                          : {exp_d[31:16], 16'h5678};
         pvmrf_mem_model_inst.write_word(v[2:0]);
         chk(wbus, exp_d, "write bus");
         chk(pvmrf_mem_model_inst.mem[v + 2], exp_d, "stored");
      end
      results();
   end
endmodule : testbench
